// ==== ccr_pkg.sv ====
// ccr_pkg: register map, field positions, reset values and modes of the comparator control block
// assumes an 8-bit register port on the core clock
package ccr_pkg;
    localparam logic [7:0] CCR_ADDR_IRQ_CONTROL = 8'h0b;
    localparam logic [7:0] CCR_ADDR_PERIPH_FLAGS = 8'h0c;
    localparam logic [7:0] CCR_ADDR_CMP_CONTROL = 8'h19;
    localparam logic [7:0] CCR_ADDR_PIN_DIRECTION = 8'h85;
    localparam logic [7:0] CCR_ADDR_PERIPH_ENABLES = 8'h8c;
    localparam logic [7:0] CCR_ADDR_REF_CONTROL = 8'h99;
    localparam logic [7:0] CCR_ADDR_PORT_PINS = 8'h05;
    localparam logic [7:0] CCR_ADDR_ANALOG_SEL = 8'h9f;

    localparam logic [7:0] CCR_RST_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] CCR_RST_PERIPH_FLAGS = 8'h00;
    localparam logic [7:0] CCR_RST_CMP_CONTROL = 8'h00;
    localparam logic [5:0] CCR_RST_PIN_DIRECTION = 6'h3f;
    localparam logic [7:0] CCR_RST_PERIPH_ENABLES = 8'h00;
    localparam logic [7:0] CCR_RST_REF_CONTROL = 8'h00;
    localparam logic [3:0] CCR_RST_ANALOG_SEL = 4'hf;

    localparam int CCR_BIT_RESULT = 6;
    localparam int CCR_BIT_INVERT = 4;
    localparam int CCR_BIT_SWITCH = 3;
    localparam int CCR_BIT_CHANGE_FLAG = 3;
    localparam int CCR_BIT_CMP_IRQ_EN = 3;
    localparam int CCR_BIT_PERIPH_IRQ_EN = 6;
    localparam int CCR_BIT_GLOBAL_IRQ_EN = 7;
    localparam int CCR_BIT_REF_POWER = 7;
    localparam int CCR_BIT_REF_RANGE = 5;
    localparam int CCR_BIT_OUT_PIN = 2;
    localparam logic [7:0] CCR_MASK_CMP_CONTROL = 8'h1f;
    localparam logic [7:0] CCR_MASK_REF_CONTROL = 8'haf;

    typedef enum logic [2:0] {
        CCR_MODE_RESET = 3'h0,
        CCR_MODE_OUT_A = 3'h1,
        CCR_MODE_OUT_B = 3'h3,
        CCR_MODE_SW_REF = 3'h5,
        CCR_MODE_SW_OUT = 3'h6,
        CCR_MODE_OFF = 3'h7
    } ccr_mode_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ccr_bus_s;

    typedef struct packed {
        logic power_on;
        logic range_low;
        logic [3:0] level;
        logic cmp_enable;
        logic input_switch;
    } ccr_analog_s;
endpackage

// ==== ccr_top.sv ====
// ccr_top: register file, result synchroniser, change detection and pin control
// assumes registers reached over a plain strobe port, comparator output asynchronous
// Contract
// - result bit six read-only
// - output modes drive result onto pin
// - direction bit two gates pin driver
// - analog-input pins read zero
// - range and level pick reference tap
// - power bit enables reference ladder
// - range bit selects low range
// - level field four bits wide
// - sleep keeps comparator and reference running
// - interrupt wakes, registers kept
// - reset loads register defaults
// - output change sets change flag
// - software writes flag zero or one
// - three enables gate interrupt
// - mismatch re-sets flag, access relatches
// - change during read may miss
// - invert bit reverses polarity
// - switch bit chooses negative input
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
module ccr_top
    import ccr_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // analog side
    input wire logic cmp_raw_in,
    input wire logic [5:0] pin_level_in,
    output ccr_analog_s analog_out,
    // pin and interrupt
    output logic out_pin_out,
    output logic out_pin_oe_out,
    output logic irq_out,
    output logic wake_out
);
    ccr_bus_s bus;
    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    logic [7:0] irq_ctrl, next_irq_ctrl;
    logic [7:0] pflags, next_pflags;
    logic [7:0] comparator_control, next_comparator_control;
    logic [5:0] pdir, next_pdir;
    logic [7:0] pen, next_pen;
    logic [7:0] reference_control, next_reference_control;
    logic [3:0] ansel, next_ansel;
    logic sync1, sync2, latched, next_latched;
    logic [7:0] next_rdata;
    logic result, next_pin, next_oe, next_irq;
    ccr_analog_s next_analog;
    logic cmp_access, mismatch, out_mode;

    // synchronised result is inverted after sync when the invert bit is set; result bit reflects polarity
    assign result = sync2 ^ comparator_control[CCR_BIT_INVERT];
    assign cmp_access = (bus.wr || bus.rd) && bus.addr == CCR_ADDR_CMP_CONTROL;
    assign mismatch = result != latched;
    assign out_mode = comparator_control[2:0] == CCR_MODE_OUT_A || comparator_control[2:0] == CCR_MODE_OUT_B
        || comparator_control[2:0] == CCR_MODE_SW_OUT;

    always_comb begin
        next_irq_ctrl = irq_ctrl;
        next_pflags = pflags;
        next_comparator_control = comparator_control;
        next_pdir = pdir;
        next_pen = pen;
        next_reference_control = reference_control;
        next_ansel = ansel;
        next_latched = latched;
        if (bus.wr) begin
            unique case (bus.addr)
                CCR_ADDR_IRQ_CONTROL: next_irq_ctrl = bus.wdata;
                CCR_ADDR_PERIPH_FLAGS: next_pflags = bus.wdata;
                CCR_ADDR_CMP_CONTROL: next_comparator_control = bus.wdata & CCR_MASK_CMP_CONTROL;
                CCR_ADDR_PIN_DIRECTION: next_pdir = bus.wdata[5:0];
                CCR_ADDR_PERIPH_ENABLES: next_pen = bus.wdata;
                CCR_ADDR_REF_CONTROL: next_reference_control = bus.wdata & CCR_MASK_REF_CONTROL;
                CCR_ADDR_ANALOG_SEL: next_ansel = bus.wdata[3:0];
                default: ;
            endcase
        end
        // access relatches; a change landing with the read may be missed
        if (cmp_access) begin
            next_latched = result;
        end else if (mismatch) begin
            next_pflags[CCR_BIT_CHANGE_FLAG] = 1'b1;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                CCR_ADDR_IRQ_CONTROL: next_rdata = irq_ctrl;
                CCR_ADDR_PERIPH_FLAGS: next_rdata = pflags;
                CCR_ADDR_CMP_CONTROL: next_rdata = comparator_control | {1'b0, result, 6'h00};
                CCR_ADDR_PIN_DIRECTION: next_rdata = {2'b00, pdir};
                CCR_ADDR_PERIPH_ENABLES: next_rdata = pen;
                CCR_ADDR_REF_CONTROL: next_rdata = reference_control;
                CCR_ADDR_ANALOG_SEL: next_rdata = {4'h0, ansel};
                CCR_ADDR_PORT_PINS: next_rdata = {2'b00, pin_level_in & ~{2'b00, ansel}};
                default: next_rdata = 8'h00;
            endcase
        end
        next_irq = pflags[CCR_BIT_CHANGE_FLAG] && pen[CCR_BIT_CMP_IRQ_EN]
            && irq_ctrl[CCR_BIT_PERIPH_IRQ_EN] && irq_ctrl[CCR_BIT_GLOBAL_IRQ_EN];
        next_pin = result;
        next_oe = out_mode && !pdir[CCR_BIT_OUT_PIN];
        next_analog.power_on = reference_control[CCR_BIT_REF_POWER];
        next_analog.range_low = reference_control[CCR_BIT_REF_RANGE];
        next_analog.level = reference_control[3:0];
        next_analog.cmp_enable = comparator_control[2:0] != CCR_MODE_RESET && comparator_control[2:0] != CCR_MODE_OFF;
        next_analog.input_switch = comparator_control[CCR_BIT_SWITCH]
            && (comparator_control[2:0] == CCR_MODE_SW_REF || comparator_control[2:0] == CCR_MODE_SW_OUT);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_ctrl <= CCR_RST_IRQ_CONTROL;
            pflags <= CCR_RST_PERIPH_FLAGS;
            comparator_control <= CCR_RST_CMP_CONTROL;
            pdir <= CCR_RST_PIN_DIRECTION;
            pen <= CCR_RST_PERIPH_ENABLES;
            reference_control <= CCR_RST_REF_CONTROL;
            ansel <= CCR_RST_ANALOG_SEL;
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            latched <= 1'b0;
            rdata_out <= 8'h00;
            out_pin_out <= 1'b0;
            out_pin_oe_out <= 1'b0;
            irq_out <= 1'b0;
            wake_out <= 1'b0;
            analog_out <= '0;
        end else begin
            irq_ctrl <= next_irq_ctrl;
            pflags <= next_pflags;
            comparator_control <= next_comparator_control;
            pdir <= next_pdir;
            pen <= next_pen;
            reference_control <= next_reference_control;
            ansel <= next_ansel;
            sync1 <= cmp_raw_in;
            sync2 <= sync1;
            latched <= next_latched;
            rdata_out <= next_rdata;
            out_pin_out <= next_pin;
            out_pin_oe_out <= next_oe;
            irq_out <= next_irq;
            wake_out <= pflags[CCR_BIT_CHANGE_FLAG] && pen[CCR_BIT_CMP_IRQ_EN];
            analog_out <= next_analog;
        end
    end

    a_read_only_result: assert property (@(posedge clk_in) disable iff (!rstn_in)
        bus.wr && bus.addr == CCR_ADDR_CMP_CONTROL |=> comparator_control[CCR_BIT_RESULT] == 1'b0)
        else $error("result bit stored by write");
    a_pin_follows: assert property (@(posedge clk_in) disable iff (!rstn_in)
        1'b1 |=> out_pin_out == $past(result))
        else $error("pin not following result");
    a_pin_enable: assert property (@(posedge clk_in) disable iff (!rstn_in)
        pdir[CCR_BIT_OUT_PIN] |=> !out_pin_oe_out)
        else $error("driver enabled while direction set");
    a_ref_fields: assert property (@(posedge clk_in) disable iff (!rstn_in)
        1'b1 |=> analog_out.level == $past(reference_control[3:0])
            && analog_out.range_low == $past(reference_control[CCR_BIT_REF_RANGE]))
        else $error("reference tap mismatch");
    a_ref_unimpl: assert property (@(posedge clk_in) disable iff (!rstn_in)
        reference_control[6] == 1'b0 && reference_control[4] == 1'b0)
        else $error("unimplemented reference bits set");
    sequence s_change;
        !cmp_access && mismatch;
    endsequence
    a_change_sets: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_change |=> pflags[CCR_BIT_CHANGE_FLAG])
        else $error("change flag not set");
    a_relatch: assert property (@(posedge clk_in) disable iff (!rstn_in)
        cmp_access |=> latched == $past(result))
        else $error("access did not relatch");
    a_irq_gate: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !pen[CCR_BIT_CMP_IRQ_EN] |=> !irq_out)
        else $error("interrupt while disabled");
    a_sync_delay: assert property (@(posedge clk_in) disable iff (!rstn_in)
        1'b1 |=> ##1 sync2 == $past(cmp_raw_in, 2))
        else $error("synchroniser depth wrong");
endmodule // ccr_top

// ==== ccr_cmp_model.sv ====
// ccr_cmp_model: behavioural analog comparator at the far side of ccr_top
// assumes the bench sets which input is higher
`timescale 1ns/1ns
module ccr_cmp_model
    import ccr_pkg::*;
(
    // control from the block
    input ccr_analog_s analog_in,
    // bench command: plus pin above minus pin
    input wire logic plus_high_in,
    // raw output
    output logic raw_out
);
    // disabled comparator sits low; switched negative input equals plus, reads low
    assign raw_out = analog_in.cmp_enable & plus_high_in & ~analog_in.input_switch;
endmodule // ccr_cmp_model

// ==== ccr_top_tb.sv ====
// ccr_top_tb: register-level bench for ccr_top
// assumes the comparator model above and a 100 MHz clock
`timescale 1ns/1ns
module ccr_top_tb;
    import ccr_pkg::*;
    logic clk_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, plus_high = 0;
    logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
    logic [5:0] pin_level_in = 6'h3f;
    logic cmp_raw, out_pin_out, out_pin_oe_out, irq_out, wake_out;
    ccr_analog_s analog_out;
    int n_fail = 0, cmp_count = 0;
    ccr_top dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cmp_raw_in(cmp_raw),
        .pin_level_in(pin_level_in), .analog_out(analog_out), .out_pin_out(out_pin_out),
        .out_pin_oe_out(out_pin_oe_out), .irq_out(irq_out), .wake_out(wake_out));
    ccr_cmp_model model (.analog_in(analog_out), .plus_high_in(plus_high), .raw_out(cmp_raw));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, exp);
    endtask
    initial begin
        tick(5000);
        n_fail++;
        give_verdict();
    end
    initial begin
        tick(20);
        rstn_in <= 1'b1;
        rd(CCR_ADDR_CMP_CONTROL, 8'h00);
        rd(CCR_ADDR_REF_CONTROL, 8'h00);
        rd(CCR_ADDR_PIN_DIRECTION, 8'h3f);
        rd(CCR_ADDR_PORT_PINS, 8'h30);
        rd(8'h42, 8'h00);
        wr(CCR_ADDR_REF_CONTROL, 8'hff);
        rd(CCR_ADDR_REF_CONTROL, 8'haf);
        chk({analog_out.power_on, analog_out.range_low, analog_out.level}, 8'h3f);
        wr(CCR_ADDR_REF_CONTROL, 8'h25);
        tick(2);
        #1 chk({analog_out.power_on, analog_out.range_low, analog_out.level}, 8'h15);
        wr(CCR_ADDR_CMP_CONTROL, 8'hff);
        tick(4);
        rd(CCR_ADDR_CMP_CONTROL, 8'h5f);
        // output mode, flag cleared, all enables on
        wr(CCR_ADDR_CMP_CONTROL, 8'h01);
        tick(4);
        rd(CCR_ADDR_CMP_CONTROL, 8'h01);
        wr(CCR_ADDR_PERIPH_FLAGS, 8'h00);
        wr(CCR_ADDR_PERIPH_ENABLES, 8'h08);
        wr(CCR_ADDR_IRQ_CONTROL, 8'hc0);
        wr(CCR_ADDR_PIN_DIRECTION, 8'h3b);
        plus_high <= 1'b1;
        tick(6);
        chk({out_pin_oe_out, out_pin_out, irq_out, wake_out}, 8'h0f);
        wr(CCR_ADDR_PIN_DIRECTION, 8'h3f);
        wr(CCR_ADDR_IRQ_CONTROL, 8'h40);
        tick(2);
        chk({out_pin_oe_out, irq_out}, 8'h00);
        wr(CCR_ADDR_PERIPH_FLAGS, 8'h00);
        tick(2);
        rd(CCR_ADDR_PERIPH_FLAGS, 8'h08);
        rd(CCR_ADDR_CMP_CONTROL, 8'h41);
        wr(CCR_ADDR_PERIPH_FLAGS, 8'h00);
        tick(2);
        rd(CCR_ADDR_PERIPH_FLAGS, 8'h00);
        wr(CCR_ADDR_PERIPH_FLAGS, 8'h08);
        rd(CCR_ADDR_PERIPH_FLAGS, 8'h08);
        wr(CCR_ADDR_CMP_CONTROL, 8'h11);
        tick(4);
        rd(CCR_ADDR_CMP_CONTROL, 8'h11);
        wr(CCR_ADDR_CMP_CONTROL, 8'h0e);
        tick(4);
        rd(CCR_ADDR_CMP_CONTROL, 8'h0e);
        wr(CCR_ADDR_CMP_CONTROL, 8'h06);
        tick(4);
        rd(CCR_ADDR_CMP_CONTROL, 8'h46);
        // second reset in mid-run
        rstn_in <= 1'b0;
        tick(2);
        rstn_in <= 1'b1;
        chk(analog_out, 8'h00);
        rd(CCR_ADDR_CMP_CONTROL, 8'h00);
        rd(CCR_ADDR_REF_CONTROL, 8'h00);
        give_verdict();
    end
endmodule // ccr_top_tb
